// ---- rtl/ctrl_exec.sv ----
/*
  Execution of no-operation, software reset, interrupt return and literal
  return. Fetch presents one instruction word with a valid flag; the block
  answers with a struct of one-cycle core control strobes.
  Assumes the core acts on the strobes in the cycle they are high and that
  the caller may present words while busy; they are ignored.
*/
`timescale 1ns/100ps
`default_nettype none
module ctrl_exec #(
  parameter int PC_WIDTH = ctrl_exec_pkg::PC_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire ctrl_exec_pkg::fetch_t fetch,
  input wire logic [PC_WIDTH-1:0] stack_top_entry,
  output ctrl_exec_pkg::core_ctl_t ctl,
  output logic busy
);
  // The carrier struct fixes the PC width, so no other value can be served
  if (PC_WIDTH != ctrl_exec_pkg::PC_W) begin : g_bad_width
    $error("PC_WIDTH must match the package");
  end

  // Idle, strobe cycle of a return, then the flush cycle of a return
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_POP = 3'b010,
    ST_FLUSH = 3'b100
  } state_t;

  state_t state_q, state_d;
  ctrl_exec_pkg::core_ctl_t ctl_q, ctl_d;

  logic is_nop, is_rst, is_rfi, is_rlw, take;
  assign take = fetch.valid && (state_q == ST_IDLE);
  assign is_nop = fetch.word == ctrl_exec_pkg::OP_NO_OPERATION;
  assign is_rst = fetch.word == ctrl_exec_pkg::OP_SOFT_RESET;
  assign is_rfi = fetch.word == ctrl_exec_pkg::OP_IRQ_RETURN;
  assign is_rlw = (fetch.word & ctrl_exec_pkg::OP_LIT_RETURN_MASK) ==
    ctrl_exec_pkg::OP_LIT_RETURN;

  always_comb begin
    state_d = state_q;
    ctl_d = '0;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (is_nop) begin
            ctl_d.pc_inc = 1'b1;
          end else if (is_rst) begin
            ctl_d.soft_reset = 1'b1;
            ctl_d.reset_cause_clear = 1'b1;
          end else if (is_rfi || is_rlw) begin
            // First cycle: pop the return address into the PC
            ctl_d.stack_pop = 1'b1;
            ctl_d.pc_load = 1'b1;
            ctl_d.pc_value = stack_top_entry;
            ctl_d.irq_enable_set = is_rfi;
            ctl_d.w_load = is_rlw;
            // Literal only for the literal return, so W data stays quiet otherwise
            if (is_rlw) begin
              ctl_d.w_value = fetch.word[ctrl_exec_pkg::LIT_LSB +: ctrl_exec_pkg::DATA_W];
            end
            state_d = ST_POP;
          end
        end
      end
      ST_POP: begin
        // Strobes stand this cycle; the next one flushes the fetched word
        state_d = ST_FLUSH;
      end
      ST_FLUSH: begin
        // Pipeline flush; no strobes
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      ctl_q <= '0;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
    end
  end

  assign ctl = ctl_q;
  assign busy = (state_q != ST_IDLE);

  property p_rst_strobes;
    @(posedge clk) disable iff (!rst_b)
      (take && is_rst) |=> (ctl.soft_reset && ctl.reset_cause_clear && !ctl.pc_load);
  endproperty
  a_rst_strobes: assert property (p_rst_strobes) else $error("soft reset not issued");

  property p_rst_cause;
    @(posedge clk) disable iff (!rst_b)
      ctl.reset_cause_clear |-> ctl.soft_reset;
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("cause clear without reset");

  sequence s_ret_take;
    take && (is_rfi || is_rlw);
  endsequence
  sequence s_ret_two;
    (ctl.pc_load && ctl.stack_pop) ##1 (!ctl.pc_load && busy);
  endsequence

  property p_ret_two_cycles;
    @(posedge clk) disable iff (!rst_b)
      s_ret_take |=> s_ret_two;
  endproperty
  a_ret_two_cycles: assert property (p_ret_two_cycles) else $error("return not two cycles");

  property p_ret_pc;
    @(posedge clk) disable iff (!rst_b)
      s_ret_take |=> (ctl.pc_value == $past(stack_top_entry));
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("PC not loaded from stack");

  property p_gie;
    @(posedge clk) disable iff (!rst_b)
      (take && is_rfi) |=> (ctl.irq_enable_set && !ctl.w_load);
  endproperty
  a_gie: assert property (p_gie) else $error("interrupt enable not set");

  property p_lit;
    @(posedge clk) disable iff (!rst_b)
      (take && is_rlw) |=> (ctl.w_load && !ctl.irq_enable_set &&
        ctl.w_value == $past(fetch.word[ctrl_exec_pkg::LIT_LSB +: ctrl_exec_pkg::DATA_W]));
  endproperty
  a_lit: assert property (p_lit) else $error("literal not written to W");

  property p_nop;
    @(posedge clk) disable iff (!rst_b)
      (take && is_nop) |=> (ctl.pc_inc && !ctl.pc_load && !ctl.w_load && !busy);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation altered state");

  property p_ret_ready;
    @(posedge clk) disable iff (!rst_b)
      s_ret_take |=> ##2 !busy;
  endproperty
  a_ret_ready: assert property (p_ret_ready) else $error("return held busy too long");

  property p_state_onehot;
    @(posedge clk) disable iff (!rst_b)
      $onehot(state_q);
  endproperty
  a_state_onehot: assert property (p_state_onehot) else $error("state not one-hot");

  property p_busy_ignore;
    @(posedge clk) disable iff (!rst_b)
      (fetch.valid && busy) |=> (ctl == '0);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("word taken while busy");

  property p_ret_no_inc;
    @(posedge clk) disable iff (!rst_b)
      s_ret_take |=> (!ctl.pc_inc && !ctl.soft_reset && !ctl.reset_cause_clear);
  endproperty
  a_ret_no_inc: assert property (p_ret_no_inc) else $error("return raised a stray strobe");

  property p_rfi_quiet_w;
    @(posedge clk) disable iff (!rst_b)
      (take && is_rfi) |=> (ctl.w_value == '0);
  endproperty
  a_rfi_quiet_w: assert property (p_rfi_quiet_w) else $error("interrupt return drove W data");

  property p_lit_pc;
    @(posedge clk) disable iff (!rst_b)
      (take && is_rlw) |=> (ctl.pc_load && ctl.stack_pop && ctl.pc_value == $past(stack_top_entry));
  endproperty
  a_lit_pc: assert property (p_lit_pc) else $error("literal return did not pop");

  property p_nop_quiet;
    @(posedge clk) disable iff (!rst_b)
      (take && is_nop) |=> (!ctl.soft_reset && !ctl.stack_pop && !ctl.irq_enable_set
        && !ctl.reset_cause_clear);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-operation raised a strobe");

  property p_unknown_quiet;
    @(posedge clk) disable iff (!rst_b)
      (take && !(is_nop || is_rst || is_rfi || is_rlw)) |=> (ctl == '0 && !busy);
  endproperty
  a_unknown_quiet: assert property (p_unknown_quiet) else $error("unknown word acted on");

  property p_flush_idle;
    @(posedge clk) disable iff (!rst_b)
      (state_q == ST_FLUSH) |=> (state_q == ST_IDLE);
  endproperty
  a_flush_idle: assert property (p_flush_idle) else $error("flush not followed by idle");

  property p_pop_pairs;
    @(posedge clk) disable iff (!rst_b)
      ctl.stack_pop |-> (ctl.pc_load && !ctl.pc_inc);
  endproperty
  a_pop_pairs: assert property (p_pop_pairs) else $error("pop without PC load");

  property p_w_only_lit;
    @(posedge clk) disable iff (!rst_b)
      ctl.w_load |-> (!ctl.irq_enable_set && ctl.stack_pop);
  endproperty
  a_w_only_lit: assert property (p_w_only_lit) else $error("W written outside literal return");

  property p_load_pulse;
    @(posedge clk) disable iff (!rst_b)
      ctl.pc_load |=> !ctl.pc_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("PC load held over one cycle");
endmodule
`default_nettype wire

// ---- rtl/ctrl_exec_pkg.sv ----
/*
  Package for the control-instruction execution block: opcodes, field
  positions, cycle counts and the carrier structs.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package ctrl_exec_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  // Opcode encodings of the handled instructions
  localparam logic [13:0] OP_NO_OPERATION = 14'h0000;
  localparam logic [13:0] OP_SOFT_RESET = 14'h0001;
  localparam logic [13:0] OP_IRQ_RETURN = 14'h0009;
  localparam logic [13:0] OP_LIT_RETURN_MASK = 14'h3F00;
  localparam logic [13:0] OP_LIT_RETURN = 14'h3400;
  localparam int LIT_LSB = 0;
  localparam int GIE_BIT = 7;
  localparam logic [1:0] RETURN_CYCLES = 2'h2;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } fetch_t;

  typedef struct packed {
    logic pc_inc;
    logic pc_load;
    logic [14:0] pc_value;
    logic stack_pop;
    logic w_load;
    logic [7:0] w_value;
    logic irq_enable_set;
    logic reset_cause_clear;
    logic soft_reset;
  } core_ctl_t;
endpackage

// ---- verif/return_reset_nop_exec_bench.sv ----
/*
  Self-checking bench for ctrl_exec: no-operation, soft reset and both returns.
  Assumes every task is entered just after a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module return_reset_nop_exec_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  ctrl_exec_pkg::fetch_t fetch = '0;
  logic [14:0] stack_top_entry = 15'h0000;
  ctrl_exec_pkg::core_ctl_t ctl;
  logic busy;
  int n_fail = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  ctrl_exec u_dut (.clk(clk), .rst_b(rst_b), .fetch(fetch),
    .stack_top_entry(stack_top_entry), .ctl(ctl), .busy(busy));
  task automatic cmp(input ctrl_exec_pkg::core_ctl_t e, input logic eb);
    num_checks++;
    if (ctl !== e || busy !== eb) begin
      n_fail++;
      $display("BAD %0t ctl %h busy %b want %h %b", $time, ctl, busy, e, eb);
    end
  endtask
  // Word is taken at the rising edge; answer is looked at half a cycle later, at the falling edge
  task automatic issue(input logic [13:0] w);
    fetch = {1'b1, w};
    @(negedge clk);
    fetch = '0;
  endtask
  task automatic t_nop;
    issue(ctrl_exec_pkg::OP_NO_OPERATION);
    cmp({2'h2, 28'h0000000}, 1'b0);
    @(negedge clk);
    cmp('0, 1'b0);
  endtask
  task automatic t_reset;
    issue(ctrl_exec_pkg::OP_SOFT_RESET);
    cmp({28'h0000000, 2'h3}, 1'b0);
    rst_b = 1'b0;
    @(negedge clk);
    cmp('0, 1'b0);
    rst_b = 1'b1;
    @(negedge clk);
  endtask
  task automatic t_ret(input logic [13:0] w, input logic irq, input logic wl,
                       input logic [7:0] wv, input logic [14:0] pc);
    stack_top_entry = pc;
    issue(w);
    cmp({1'b0, 1'b1, pc, 1'b1, wl, wv, irq, 2'h0}, 1'b1);
    // A word offered while busy must be ignored
    fetch = {1'b1, ctrl_exec_pkg::OP_SOFT_RESET};
    @(negedge clk);
    fetch = '0;
    cmp('0, 1'b1);
    @(negedge clk);
    cmp('0, 1'b0);
    stack_top_entry = ~pc;
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    cmp('0, 1'b0);
    rst_b = 1'b1;
    @(negedge clk);
    t_nop();
    t_reset();
    t_ret(ctrl_exec_pkg::OP_IRQ_RETURN, 1'b1, 1'b0, 8'h00, 15'h7FFF);
    t_ret(ctrl_exec_pkg::OP_LIT_RETURN | 14'h00FF, 1'b0, 1'b1, 8'hFF, 15'h0001);
    t_ret(ctrl_exec_pkg::OP_LIT_RETURN, 1'b0, 1'b1, 8'h00, 15'h2AAA);
    t_ret(ctrl_exec_pkg::OP_LIT_RETURN | 14'h005A, 1'b0, 1'b1, 8'h5A, 15'h5555);
    issue(14'h3FFF);
    cmp('0, 1'b0);
    t_nop();
    close_out();
  end
endmodule
`default_nettype wire
